// [design/tcc_pkg.sv]
package tcc_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets on the internal bus
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL = 8'h12;
    localparam logic [7:0] OFS_FLAGS = 8'h13;
    localparam logic [7:0] OFS_CAP_HI = 8'h14;
    localparam logic [7:0] OFS_CAP_LO = 8'h15;
    localparam logic [7:0] OFS_CMP_HI = 8'h16;
    localparam logic [7:0] OFS_CMP_LO = 8'h17;
    localparam logic [7:0] OFS_CNT_HI = 8'h18;
    localparam logic [7:0] OFS_CNT_LO = 8'h19;
    localparam logic [7:0] OFS_ALT_HI = 8'h1A;
    localparam logic [7:0] OFS_ALT_LO = 8'h1B;

    // ------------------------------------------------------------------
    // Field positions in timer_control and timer_flags
    // ------------------------------------------------------------------
    localparam int BIT_CAPTURE = 7;
    localparam int BIT_MATCH = 6;
    localparam int BIT_WRAP = 5;
    localparam int BIT_EDGE_SEL = 1;
    localparam int BIT_LEVEL = 0;

    // Index of each event inside the three-wide flag and enable vectors.
    localparam int EV_CAPTURE = 2;
    localparam int EV_MATCH = 1;
    localparam int EV_WRAP = 0;

    // ------------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------------
    localparam logic [15:0] CNT_RESET = 16'hFFFC;
    localparam logic [15:0] CNT_TOP = 16'hFFFF;
    localparam logic [2:0] ENABLES_RESET = 3'h0;
    localparam logic LEVEL_RESET = 1'b0;
    localparam logic EDGE_SEL_POR = 1'b0;
    localparam int PRESCALE_DIV = 4;
    localparam int OSC_START_CYC = 4064;
    localparam int CAP_LAG_STAGES = 2;

    // ------------------------------------------------------------------
    // Bus request carrier
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } tcc_bus_req_t;

endpackage

// [design/tcc_timer.sv]
`timescale 1ns/100ps
`default_nettype none

module tcc_timer #(
    parameter int OSC_START = tcc_pkg::OSC_START_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic por,
    input wire tcc_pkg::tcc_bus_req_t bus,
    output logic [7:0] rdata,
    input wire logic stop_mode,
    input wire logic capture_in_pin,
    output logic match_out_pin,
    output logic timer_irq
);

    // The start-up wait counter is sixteen bits wide, and a zero wait
    // would leave the power-on path untested by the logic below.
    if (OSC_START < 1 || OSC_START > 65535) begin : g_bad_osc
        $error("OSC_START out of range");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [1:0] presc_r;
    logic [15:0] free_count_r;
    logic [15:0] cnt_d1_r;
    logic [15:0] cnt_d2_r;
    logic [15:0] osc_wait_r;
    logic [7:0] cnt_buf_r;
    logic cnt_buf_held_r;
    logic [15:0] capture_value_r;
    logic cap_lock_r;
    logic [15:0] compare_value_r;
    logic cmp_hold_r;
    logic [2:0] irq_en_r;
    logic capture_edge_sel_r;
    logic match_level_bit_r;
    logic [2:0] flags_r;
    logic [2:0] clr_arm_r;
    logic tick_d_r;
    logic pin_s1_r;
    logic pin_s2_r;
    logic pin_s3_r;
    logic stop_d_r;
    logic stop_armed_r;
    logic [15:0] stop_cap_r;
    logic match_out_r;
    logic [7:0] rdata_r;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // The core never raises rd and wr together, so each strobe is decoded
    // on its own and status accesses count either direction.
    wire logic rd_ctl = bus.rd && bus.addr == tcc_pkg::OFS_CONTROL;
    wire logic wr_ctl = bus.wr && bus.addr == tcc_pkg::OFS_CONTROL;
    wire logic acc_flags = (bus.rd || bus.wr)
        && bus.addr == tcc_pkg::OFS_FLAGS;
    wire logic rd_cap_hi = bus.rd && bus.addr == tcc_pkg::OFS_CAP_HI;
    wire logic rd_cap_lo = bus.rd && bus.addr == tcc_pkg::OFS_CAP_LO;
    wire logic wr_cmp_hi = bus.wr && bus.addr == tcc_pkg::OFS_CMP_HI;
    wire logic wr_cmp_lo = bus.wr && bus.addr == tcc_pkg::OFS_CMP_LO;
    wire logic acc_cmp_lo = (bus.rd || bus.wr)
        && bus.addr == tcc_pkg::OFS_CMP_LO;
    wire logic rd_cnt_hi = bus.rd && bus.addr == tcc_pkg::OFS_CNT_HI;
    wire logic rd_cnt_lo = bus.rd && bus.addr == tcc_pkg::OFS_CNT_LO;
    wire logic rd_alt_hi = bus.rd && bus.addr == tcc_pkg::OFS_ALT_HI;
    wire logic rd_alt_lo = bus.rd && bus.addr == tcc_pkg::OFS_ALT_LO;
    wire logic rd_any_hi = rd_cnt_hi || rd_alt_hi;
    wire logic rd_any_lo = rd_cnt_lo || rd_alt_lo;

    // ------------------------------------------------------------------
    // Prescaler and free-running counter
    // ------------------------------------------------------------------
    // The counter stays still while stopped and during the start-up wait.
    // Clearing the prescaler on stop entry makes the first step after an
    // interrupt exit a full four cycles away, as from any other start.
    // The wrap is taken from the step itself, so it is seen exactly once.
    wire logic osc_ready = osc_wait_r == 16'h0000;
    wire logic running = osc_ready && !stop_mode;
    wire logic stop_enter = stop_mode && !stop_d_r;
    wire logic stop_leave = !stop_mode && stop_d_r;
    wire logic presc_last = presc_r == 2'(tcc_pkg::PRESCALE_DIV - 1);
    wire logic tick = running && presc_last;
    wire logic wrap = tick && free_count_r == tcc_pkg::CNT_TOP;
    wire logic [1:0] presc_nxt = stop_enter ? 2'h0
        : running ? presc_r + 2'h1 : presc_r;
    wire logic [15:0] free_count_nxt = tick ? free_count_r + 16'h0001
        : free_count_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            presc_r <= 2'h0;
            free_count_r <= tcc_pkg::CNT_RESET;
            tick_d_r <= 1'b0;
        end else begin
            presc_r <= presc_nxt;
            free_count_r <= free_count_nxt;
            tick_d_r <= tick;
        end
    end

    // A power-on reset holds the counter until the oscillator settles.
    always_ff @(posedge clk) begin
        if (srst) begin
            osc_wait_r <= por ? 16'(OSC_START) : 16'h0000;
        end else if (!osc_ready) begin
            osc_wait_r <= osc_wait_r - 16'h0001;
        end
    end

    // ------------------------------------------------------------------
    // Counter read buffer
    // ------------------------------------------------------------------
    // Both counter images share this one buffer; a program that mixes
    // the two images inside one sequence still reads a consistent pair.
    // Only the first high-byte read captures the low byte, so repeated
    // high reads still pair with the low byte of the first one.
    wire logic buf_take = rd_any_hi && !cnt_buf_held_r;
    wire logic buf_held_nxt = rd_any_lo ? 1'b0
        : rd_any_hi ? 1'b1 : cnt_buf_held_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_buf_held_r <= 1'b0;
            cnt_buf_r <= 8'h00;
        end else begin
            cnt_buf_held_r <= buf_held_nxt;
            if (buf_take) begin
                cnt_buf_r <= free_count_r[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Output compare
    // ------------------------------------------------------------------
    // Matching is judged once per counter step, right after the step, so
    // one counter value raises one match however long it stands.
    wire logic match = tick_d_r && !cmp_hold_r
        && compare_value_r == free_count_r;
    wire logic cmp_hold_nxt = wr_cmp_lo ? 1'b0
        : wr_cmp_hi ? 1'b1 : cmp_hold_r;

    // The compare bytes carry no reset, so software may keep data in them
    // across resets when the compare function is not wanted.
    always_ff @(posedge clk) begin
        if (wr_cmp_hi) begin
            compare_value_r[15:8] <= bus.wdata;
        end
        if (wr_cmp_lo) begin
            compare_value_r[7:0] <= bus.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cmp_hold_r <= 1'b0;
            match_out_r <= tcc_pkg::LEVEL_RESET;
        end else begin
            cmp_hold_r <= cmp_hold_nxt;
            if (match) begin
                match_out_r <= match_level_bit_r;
            end
        end
    end

    // ------------------------------------------------------------------
    // Input capture
    // ------------------------------------------------------------------
    // The pin passes two flip-flops; a third holds the previous level
    // for the edge detector.
    always_ff @(posedge clk) begin
        if (srst) begin
            pin_s1_r <= 1'b0;
            pin_s2_r <= 1'b0;
            pin_s3_r <= 1'b0;
        end else begin
            pin_s1_r <= capture_in_pin;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

    // The counter is delayed by the synchroniser lag, and the stored value
    // is one above the count at the clock edge before the pin moved.
    always_ff @(posedge clk) begin
        cnt_d1_r <= free_count_r;
        cnt_d2_r <= cnt_d1_r;
    end

    wire logic rise = pin_s2_r && !pin_s3_r;
    wire logic fall = !pin_s2_r && pin_s3_r;
    wire logic cap_edge = capture_edge_sel_r ? rise : fall;
    wire logic [15:0] cap_sample = cnt_d2_r + 16'h0001;
    wire logic cap_run = cap_edge && !stop_mode && !cap_lock_r;
    wire logic cap_arm = cap_edge && stop_mode && !stop_armed_r;
    wire logic cap_resume = stop_leave && stop_armed_r;
    wire logic cap_lock_nxt = rd_cap_lo ? 1'b0
        : rd_cap_hi ? 1'b1 : cap_lock_r;

    // The capture data has no reset; a reset out of stop simply drops
    // the armed sample instead of copying it.
    // The lock is not applied to the armed sample: it belongs to an edge
    // that came while the core could not have started a read sequence.
    always_ff @(posedge clk) begin
        if (cap_run) begin
            capture_value_r <= cap_sample;
        end else if (!srst && cap_resume) begin
            capture_value_r <= stop_cap_r;
        end
        if (cap_arm) begin
            stop_cap_r <= cap_sample;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cap_lock_r <= 1'b0;
            stop_d_r <= 1'b0;
            stop_armed_r <= 1'b0;
        end else begin
            cap_lock_r <= cap_lock_nxt;
            stop_d_r <= stop_mode;
            if (cap_arm) begin
                stop_armed_r <= 1'b1;
            end else if (stop_leave) begin
                stop_armed_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    // Stop entry wins over a write in the same cycle, so no enable can
    // survive into stop and leave a request standing there.
    wire logic [2:0] wr_enables = {bus.wdata[tcc_pkg::BIT_CAPTURE],
        bus.wdata[tcc_pkg::BIT_MATCH], bus.wdata[tcc_pkg::BIT_WRAP]};
    wire logic [2:0] irq_en_nxt = stop_enter ? 3'h0
        : wr_ctl ? wr_enables : irq_en_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            irq_en_r <= tcc_pkg::ENABLES_RESET;
            match_level_bit_r <= tcc_pkg::LEVEL_RESET;
        end else begin
            irq_en_r <= irq_en_nxt;
            if (wr_ctl) begin
                match_level_bit_r <= bus.wdata[tcc_pkg::BIT_LEVEL];
            end
        end
    end

    // Edge select survives ordinary resets; only power-on defines it.
    always_ff @(posedge clk) begin
        if (srst && por) begin
            capture_edge_sel_r <= tcc_pkg::EDGE_SEL_POR;
        end else if (!srst && wr_ctl) begin
            capture_edge_sel_r <= bus.wdata[tcc_pkg::BIT_EDGE_SEL];
        end
    end

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------
    // The alternate counter bytes are left out of the low-access vector.
    // A set in the same cycle as a clearing access wins, so an event that
    // lands during service is never lost.
    wire logic set_capture = cap_run || cap_resume;
    wire logic set_match = match;
    wire logic set_wrap = wrap;
    wire logic [2:0] flag_set = {set_capture, set_match, set_wrap};
    wire logic [2:0] low_acc = {rd_cap_lo, acc_cmp_lo, rd_cnt_lo};
    wire logic [2:0] flag_clr = clr_arm_r & low_acc;
    wire logic [2:0] flags_nxt = (flags_r & ~flag_clr) | flag_set;
    wire logic [2:0] clr_arm_nxt = (clr_arm_r & ~low_acc)
        | ({3{acc_flags}} & flags_r);

    always_ff @(posedge clk) begin
        if (srst) begin
            flags_r <= 3'h0;
            clr_arm_r <= 3'h0;
        end else begin
            flags_r <= flags_nxt;
            clr_arm_r <= clr_arm_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    wire logic [7:0] ctl_view = {irq_en_r, 3'b000, capture_edge_sel_r,
        match_level_bit_r};
    wire logic [7:0] flag_view = {flags_r, 5'b00000};
    wire logic [7:0] cnt_lo_view = cnt_buf_held_r ? cnt_buf_r
        : free_count_r[7:0];
    // Unmapped addresses read zero; read data only moves on a read, so a
    // slow core may pick it up any time before its next read.
    logic [7:0] rd_mux;

    always_comb begin
        case (bus.addr)
            tcc_pkg::OFS_CONTROL: rd_mux = ctl_view;
            tcc_pkg::OFS_FLAGS: rd_mux = flag_view;
            tcc_pkg::OFS_CAP_HI: rd_mux = capture_value_r[15:8];
            tcc_pkg::OFS_CAP_LO: rd_mux = capture_value_r[7:0];
            tcc_pkg::OFS_CMP_HI: rd_mux = compare_value_r[15:8];
            tcc_pkg::OFS_CMP_LO: rd_mux = compare_value_r[7:0];
            tcc_pkg::OFS_CNT_HI: rd_mux = free_count_r[15:8];
            tcc_pkg::OFS_CNT_LO: rd_mux = cnt_lo_view;
            tcc_pkg::OFS_ALT_HI: rd_mux = free_count_r[15:8];
            tcc_pkg::OFS_ALT_LO: rd_mux = cnt_lo_view;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_r <= 8'h00;
        end else if (bus.rd) begin
            rdata_r <= rd_mux;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Wait mode needs nothing here: the request below stays live and is
    // what wakes the core.
    // The request is built from registers only, so it drops in the cycle
    // after the access that clears its flag.
    assign timer_irq = |(flags_r & irq_en_r);
    assign match_out_pin = match_out_r;
    assign rdata = rdata_r;

endmodule

`default_nettype wire

// [testbench/tcc_timer_monitor.sv]
`timescale 1ns/100ps
`default_nettype none

module tcc_timer_monitor (
    input wire logic clk,
    input wire logic srst,
    input wire logic por,
    input wire tcc_pkg::tcc_bus_req_t bus,
    input wire logic [7:0] rdata,
    input wire logic stop_mode,
    input wire logic capture_in_pin,
    input wire logic match_out_pin,
    input wire logic timer_irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    wire rd_ctl = bus.rd && bus.addr == tcc_pkg::OFS_CONTROL;
    wire rd_flags = bus.rd && bus.addr == tcc_pkg::OFS_FLAGS;
    wire rd_cnt_hi = bus.rd && bus.addr == tcc_pkg::OFS_CNT_HI;

    out_reset_a: assert property ($fell(srst) |->
        rdata == 8'h00 && !match_out_pin && !timer_irq)
        else $error("outputs not cleared by reset");
    cnt_reset_a: assert property ($fell(srst) ##1 rd_cnt_hi |=>
        rdata == 8'hFF) else $error("counter high byte not FF after reset");
    rdata_hold_a: assert property (!bus.rd |=> $stable(rdata))
        else $error("read data moved without a read");
    ctl_unused_a: assert property (rd_ctl |=> rdata[4:2] == 3'h0)
        else $error("unused control bits not zero");
    flag_unused_a: assert property (rd_flags |=> rdata[4:0] == 5'h00)
        else $error("unused status bits not zero");
    irq_enable_a: assert property (rd_ctl |=>
        (rdata[7:5] != 3'h0 || !timer_irq))
        else $error("interrupt with all enables clear");
    stop_irq_a: assert property ($rose(stop_mode) |=> !timer_irq)
        else $error("interrupt request left standing in stop");
    stop_pin_a: assert property (stop_mode [*4] |->
        $stable(match_out_pin)) else $error("compare pin moved in stop");
endmodule

bind tcc_timer tcc_timer_monitor u_mon (.clk(clk), .srst(srst), .por(por),
    .bus(bus), .rdata(rdata), .stop_mode(stop_mode),
    .capture_in_pin(capture_in_pin), .match_out_pin(match_out_pin),
    .timer_irq(timer_irq));

`default_nettype wire

// [testbench/tcc_core_model.sv]
`timescale 1ns/100ps
`default_nettype none

// Core side of the byte bus. Strobes last one cycle; the address is
// inverted once released so that nothing relies on a stale value.
module tcc_core_model (
    input wire logic clk,
    output var tcc_pkg::tcc_bus_req_t bus,
    input wire logic [7:0] rdata
);
    initial bus = '0;

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1 bus.addr = a;
        bus.rd = 1'b1;
        @(posedge clk);
        #1 bus.rd = 1'b0;
        bus.addr = ~a;
        d = rdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 bus.addr = a;
        bus.wdata = d;
        bus.wr = 1'b1;
        @(posedge clk);
        #1 bus.wr = 1'b0;
        bus.addr = ~a;
        bus.wdata = ~d;
    endtask

    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        logic [7:0] h;
        logic [7:0] l;
        rd(a, h);
        rd(a + 8'h01, l);
        v = {h, l};
    endtask

    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        wr(a, v[15:8]);
        wr(a + 8'h01, v[7:0]);
    endtask
endmodule

`default_nettype wire

// [testbench/timer_capture_compare_16bit_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none

module timer_capture_compare_16bit_tb_top;
    logic clk, srst, por, stop_mode, cap_pin, match_pin, irq;
    tcc_pkg::tcc_bus_req_t bus;
    logic [7:0] rdata, d;
    logic [15:0] v, w, c1, c2;
    int errors, n_compared, cyc;

    // A short oscillator delay keeps the power-on case quick.
    tcc_timer #(.OSC_START(8)) dut (.clk(clk), .srst(srst), .por(por),
        .bus(bus), .rdata(rdata), .stop_mode(stop_mode),
        .capture_in_pin(cap_pin), .match_out_pin(match_pin),
        .timer_irq(irq));
    tcc_core_model core (.clk(clk), .bus(bus), .rdata(rdata));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic do_reset(input logic p);
        tick(1);
        srst = 1'b1;
        por = p;
        tick(3);
        srst = 1'b0;
    endtask

    task automatic t_regs();
        do_reset(1'b1);
        core.rd16(tcc_pkg::OFS_CNT_HI, v);
        chk("count after reset", 16'hFFFC, v);
        core.rd(tcc_pkg::OFS_CONTROL, d);
        chk("control reset", 16'h0000, {8'h00, d});
        core.wr(tcc_pkg::OFS_FLAGS, 8'hFF);
        core.rd(tcc_pkg::OFS_FLAGS, d);
        chk("flags read-only", 16'h0000, {8'h00, d});
        core.rd(8'h20, d);
        chk("unmapped read", 16'h0000, {8'h00, d});
        core.wr(tcc_pkg::OFS_CONTROL, 8'hFF);
        core.rd(tcc_pkg::OFS_CONTROL, d);
        chk("control bits", 16'h00E3, {8'h00, d});
        core.wr16(tcc_pkg::OFS_CMP_HI, 16'h8000);
        $display("done registers");
    endtask

    task automatic t_wrap();
        do_reset(1'b0);
        core.rd16(tcc_pkg::OFS_CNT_HI, v);
        chk("count after reset", 16'hFFFC, v);
        core.rd16(tcc_pkg::OFS_CMP_HI, v);
        chk("compare kept", 16'h8000, v);
        core.rd(tcc_pkg::OFS_CONTROL, d);
        chk("edge select kept", 16'h0002, {8'h00, d});
        core.wr(tcc_pkg::OFS_CONTROL, 8'h22);
        tick(30);
        core.rd(tcc_pkg::OFS_FLAGS, d);
        chk("wrap flag", 16'h0020, {8'h00, d});
        chk("wrap irq", 16'h0001, {15'h0, irq});
        core.rd(tcc_pkg::OFS_ALT_LO, d);
        core.rd(tcc_pkg::OFS_FLAGS, d);
        chk("alt no clear", 16'h0020, {8'h00, d});
        core.rd(tcc_pkg::OFS_CNT_LO, d);
        core.rd(tcc_pkg::OFS_FLAGS, d);
        chk("wrap cleared", 16'h0000, {8'h00, d});
        $display("done wrap");
    endtask

    task automatic t_match();
        core.wr(tcc_pkg::OFS_CONTROL, 8'h41);
        core.rd16(tcc_pkg::OFS_CNT_HI, v);
        core.wr16(tcc_pkg::OFS_CMP_HI, v + 16'h0008);
        tick(50);
        chk("pin high", 16'h0001, {15'h0, match_pin});
        chk("irq match", 16'h0001, {15'h0, irq});
        core.rd(tcc_pkg::OFS_FLAGS, d);
        chk("match flag", 16'h0040, {8'h00, d});
        core.rd(tcc_pkg::OFS_CMP_LO, d);
        chk("irq dropped", 16'h0000, {15'h0, irq});
        core.wr(tcc_pkg::OFS_CONTROL, 8'h40);
        core.rd16(tcc_pkg::OFS_CNT_HI, v);
        w = v + 16'h000C;
        core.wr16(tcc_pkg::OFS_CMP_HI, w);
        core.wr(tcc_pkg::OFS_CMP_HI, w[15:8]);
        tick(80);
        chk("suspended", 16'h0001, {15'h0, match_pin});
        core.wr(tcc_pkg::OFS_CMP_LO, w[7:0]);
        core.rd16(tcc_pkg::OFS_CNT_HI, v);
        v = v + 16'h0008;
        core.wr(tcc_pkg::OFS_CMP_LO, v[7:0]);
        tick(50);
        chk("lone low match", 16'h0000, {15'h0, match_pin});
        core.rd16(tcc_pkg::OFS_CMP_HI, c1);
        chk("bytes apart", {w[15:8], v[7:0]}, c1);
        $display("done compare");
    endtask

    task automatic t_capture();
        core.wr(tcc_pkg::OFS_CONTROL, 8'h82);
        core.rd16(tcc_pkg::OFS_CNT_HI, v);
        cap_pin = 1'b1;
        tick(6);
        core.rd16(tcc_pkg::OFS_CNT_HI, w);
        core.rd16(tcc_pkg::OFS_CAP_HI, c1);
        chk("capture window", 16'h0001, {15'h0, c1 > v && c1 <= w});
        core.rd(tcc_pkg::OFS_FLAGS, d);
        chk("capture flag", 16'h0080, {8'h00, d & 8'h80});
        core.wr(tcc_pkg::OFS_CONTROL, 8'h80);
        core.rd(tcc_pkg::OFS_CAP_HI, d);
        cap_pin = 1'b0;
        tick(8);
        core.rd(tcc_pkg::OFS_CAP_LO, d);
        core.rd16(tcc_pkg::OFS_CAP_HI, c2);
        chk("capture locked", c1, c2);
        cap_pin = 1'b1;
        tick(6);
        cap_pin = 1'b0;
        tick(6);
        core.rd16(tcc_pkg::OFS_CAP_HI, c2);
        chk("falling capture", 16'h0001, {15'h0, c2 > c1});
        core.rd(tcc_pkg::OFS_FLAGS, d);
        core.rd(tcc_pkg::OFS_CAP_LO, d);
        core.rd(tcc_pkg::OFS_FLAGS, d);
        chk("capture cleared", 16'h0000, {8'h00, d & 8'h80});
        $display("done capture");
    endtask

    task automatic t_stop();
        core.wr(tcc_pkg::OFS_CONTROL, 8'h82);
        core.rd16(tcc_pkg::OFS_CNT_HI, v);
        stop_mode = 1'b1;
        tick(5);
        core.rd(tcc_pkg::OFS_CNT_LO, d);
        core.rd16(tcc_pkg::OFS_ALT_HI, c2);
        chk("lone low live", {8'h00, c2[7:0]}, {8'h00, d});
        cap_pin = 1'b1;
        tick(20);
        stop_mode = 1'b0;
        tick(4);
        core.rd(tcc_pkg::OFS_CONTROL, d);
        chk("stop enables", 16'h0002, {8'h00, d});
        core.rd16(tcc_pkg::OFS_CNT_HI, w);
        chk("stop halt", 16'h0001, {15'h0, (w - v) < 16'h0006});
        core.rd(tcc_pkg::OFS_FLAGS, d);
        chk("stop capture", 16'h0080, {8'h00, d & 8'h80});
        core.rd16(tcc_pkg::OFS_CAP_HI, c1);
        chk("stop value", 16'h0001, {15'h0, c1 > v && c1 <= w});
        $display("done stop");
    endtask

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // The whole sequence needs under two thousand cycles.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            errors++;
            summarize();
        end
    end

    initial begin
        srst = 1'b1;
        por = 1'b1;
        stop_mode = 1'b0;
        cap_pin = 1'b0;
        errors = 0;
        n_compared = 0;
        cyc = 0;
        t_regs();
        t_wrap();
        t_match();
        t_capture();
        t_stop();
        summarize();
    end
endmodule

`default_nettype wire
